// File: src/cpwm_top.sv
// Contract
// RULE1: Positive level select 0 gives high initial, low active levels; 1 inverts.
// RULE2: Software loads six setup registers before selecting the mode.
// RULE3: Software writes the dead-time enable only to disable dead time.
// RULE4: The ch3 period buffer feeds the ch3 period compare; load half cycle plus dead time.
// RULE5: The cycle buffer feeds the cycle data register; load half the carrier cycle.
// RULE6: Software writes the dead time into the dead-time data register first.
// RULE7: Without dead time, clear enable, set period regs to half cycle plus 1, data to 1.
// RULE8: Software loads the three phase duty buffers before entering the mode.
// RULE9: On mode entry all five buffers copy to their compare registers at once.
// RULE10: Software clears the ch4 counter before selecting the mode.
// RULE11: The dead-time data value is the ch3 counter start value.
// RULE12: Positive and negative pulses never overlap unless dead time is disabled.
// RULE13: Dead-time enable clears only on a 0 write after it was read as 1.
// RULE14: Software leaves the mode before changing levels or dead-time data.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
module cpwm_top
    import cpwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output cpwm_pkg::cpwm_pins_t pwm_o
);
    import cpwm_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [3:0] mode_r;
    logic [1:0] level_r;
    logic dten_r;
    logic dten_seen_r;
    logic [CPWM_W-1:0] dtdata_r;
    logic [CPWM_W-1:0] cycbuf_r;
    logic [CPWM_W-1:0] perbuf_r;
    logic [CPWM_W-1:0] duty_r [3];
    logic [CPWM_W-1:0] cnt4_r;
    logic [CPWM_W-1:0] cnt3_r;
    logic [CPWM_W-1:0] cycdata_r;
    logic [CPWM_W-1:0] percmp_r;
    logic up_r;
    cpwm_state_t state_r;
    logic [31:0] prdata_nxt;

    // ****************************************
    // Bus decode
    // ****************************************
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire [CPWM_W-1:0] wd = pwdata[CPWM_W-1:0];
    wire comp_sel = (mode_r == CPWM_MODE_COMP);
    wire entry = comp_sel && (state_r == CPWM_IDLE);
    wire run = (state_r == CPWM_RUN);
    wire wr_mode = wr && (paddr == CPWM_ADDR_MODE);
    wire wr_mode_comp = wr_mode && (pwdata[3:0] == CPWM_MODE_COMP);
    wire hit = (paddr <= CPWM_ADDR_STATUS) && (paddr[1:0] == 2'b00);

    // ****************************************
    // Counters: ch4 leads, ch3 lags by dead time
    // ****************************************
    wire at_top = (cnt4_r >= cycdata_r);
    wire at_bot = (cnt4_r == CPWM_RST_CNT);
    // Direction for this step: turn round at crest and trough, no wrap
    wire cnt_up = up_r ? !at_top : at_bot;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= CPWM_IDLE;
        end else begin
            unique case (state_r)
                CPWM_IDLE: begin
                    if (comp_sel) begin
                        state_r <= CPWM_RUN;
                    end
                end
                CPWM_RUN: begin
                    if (!comp_sel) begin
                        state_r <= CPWM_IDLE;
                    end
                end
                default: state_r <= CPWM_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt4_r <= CPWM_RST_CNT;
            cnt3_r <= CPWM_RST_CNT;
            up_r <= 1'b1;
            cycdata_r <= CPWM_RST_CMP;
            percmp_r <= CPWM_RST_CMP;
        end else if (entry) begin
            cycdata_r <= cycbuf_r; // RULE5 RULE9
            percmp_r <= perbuf_r; // RULE4 RULE9
            cnt3_r <= dtdata_r; // RULE11
            up_r <= 1'b1;
        end else if (run) begin
            up_r <= cnt_up;
            if (!up_r && at_bot) begin
                cycdata_r <= cycbuf_r; // RULE5
                percmp_r <= perbuf_r; // RULE4
            end
            cnt4_r <= cnt_up ? cnt4_r + CPWM_ONE : cnt4_r - CPWM_ONE;
            cnt3_r <= cnt_up ? cnt3_r + CPWM_ONE : cnt3_r - CPWM_ONE;
        end else begin
            if (wr && paddr == CPWM_ADDR_CNT4) begin
                cnt4_r <= wd; // RULE10
            end
            if (wr && paddr == CPWM_ADDR_CNT3) begin
                cnt3_r <= wd;
            end
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= CPWM_MODE_NORMAL;
            level_r <= 2'b00;
            dten_r <= CPWM_RST_DTEN;
            dten_seen_r <= 1'b0;
            dtdata_r <= CPWM_RST_DT;
            cycbuf_r <= CPWM_RST_CMP;
            perbuf_r <= CPWM_RST_CMP;
            duty_r[0] <= CPWM_RST_CMP;
            duty_r[1] <= CPWM_RST_CMP;
            duty_r[2] <= CPWM_RST_CMP;
        end else begin
            if (wr_mode) begin
                mode_r <= pwdata[3:0]; // RULE2
            end
            if (wr && paddr == CPWM_ADDR_LEVEL && !run && !wr_mode_comp) begin
                level_r <= pwdata[1:0]; // RULE14
            end
            if (rd && paddr == CPWM_ADDR_DTEN && dten_r) begin
                dten_seen_r <= 1'b1;
            end
            if (wr && paddr == CPWM_ADDR_DTEN) begin
                if (!pwdata[0] && dten_seen_r) begin
                    dten_r <= 1'b0; // RULE13 RULE3
                end
                dten_seen_r <= 1'b0;
            end
            if (wr && paddr == CPWM_ADDR_DTDATA && !run) begin
                dtdata_r <= wd; // RULE6 RULE7 RULE14
            end
            if (wr && paddr == CPWM_ADDR_CYCBUF) begin
                cycbuf_r <= wd;
            end
            if (wr && paddr == CPWM_ADDR_PERBUF) begin
                perbuf_r <= wd;
            end
            if (wr && paddr == CPWM_ADDR_DUTYU) begin
                duty_r[0] <= wd; // RULE8
            end
            if (wr && paddr == CPWM_ADDR_DUTYV) begin
                duty_r[1] <= wd; // RULE8
            end
            if (wr && paddr == CPWM_ADDR_DUTYW) begin
                duty_r[2] <= wd; // RULE8
            end
        end
    end

    // ****************************************
    // Read mux and response
    // ****************************************
    always_comb begin
        prdata_nxt = CPWM_ZERO32;
        unique case (paddr)
            CPWM_ADDR_MODE: prdata_nxt[3:0] = mode_r;
            CPWM_ADDR_LEVEL: prdata_nxt[1:0] = level_r;
            CPWM_ADDR_DTEN: prdata_nxt[0] = dten_r;
            CPWM_ADDR_DTDATA: prdata_nxt[15:0] = dtdata_r;
            CPWM_ADDR_CYCBUF: prdata_nxt[15:0] = cycbuf_r;
            CPWM_ADDR_PERBUF: prdata_nxt[15:0] = perbuf_r;
            CPWM_ADDR_DUTYU: prdata_nxt[15:0] = duty_r[0];
            CPWM_ADDR_DUTYV: prdata_nxt[15:0] = duty_r[1];
            CPWM_ADDR_DUTYW: prdata_nxt[15:0] = duty_r[2];
            CPWM_ADDR_CNT4: prdata_nxt[15:0] = cnt4_r;
            CPWM_ADDR_CNT3: prdata_nxt[15:0] = cnt3_r;
            CPWM_ADDR_CYCDATA: prdata_nxt[15:0] = cycdata_r;
            CPWM_ADDR_PERCMP: prdata_nxt[15:0] = percmp_r;
            CPWM_ADDR_STATUS: prdata_nxt[1:0] = {up_r, run};
            default: prdata_nxt = CPWM_ZERO32;
        endcase
    end

    // Registered answer: pready in the first access cycle, right after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= CPWM_ZERO32;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= prdata_nxt;
        end
    end

    // ****************************************
    // Phase outputs
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_ph
            cpwm_phase u_ph (
                .pclk(pclk),
                .presetn(presetn),
                .run(run),
                .load(entry),
                .up(up_r),
                .cnt3(cnt3_r),
                .cnt4(cnt4_r),
                .duty(duty_r[g]),
                .lvl_p(level_r[CPWM_LVL_P_BIT]),
                .lvl_n(level_r[CPWM_LVL_N_BIT]),
                .dt_en(dten_r),
                .pos(pwm_o.pos[g]),
                .neg(pwm_o.neg[g])
            );
        end
    endgenerate
endmodule

// File: src/cpwm_pkg.sv
package cpwm_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CPWM_ADDR_MODE = 8'h00;
    localparam logic [7:0] CPWM_ADDR_LEVEL = 8'h04;
    localparam logic [7:0] CPWM_ADDR_DTEN = 8'h08;
    localparam logic [7:0] CPWM_ADDR_DTDATA = 8'h0C;
    localparam logic [7:0] CPWM_ADDR_CYCBUF = 8'h10;
    localparam logic [7:0] CPWM_ADDR_PERBUF = 8'h14;
    localparam logic [7:0] CPWM_ADDR_DUTYU = 8'h18;
    localparam logic [7:0] CPWM_ADDR_DUTYV = 8'h1C;
    localparam logic [7:0] CPWM_ADDR_DUTYW = 8'h20;
    localparam logic [7:0] CPWM_ADDR_CNT4 = 8'h24;
    localparam logic [7:0] CPWM_ADDR_CNT3 = 8'h28;
    localparam logic [7:0] CPWM_ADDR_CYCDATA = 8'h2C;
    localparam logic [7:0] CPWM_ADDR_PERCMP = 8'h30;
    localparam logic [7:0] CPWM_ADDR_STATUS = 8'h34;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int CPWM_W = 16;
    localparam logic [3:0] CPWM_MODE_NORMAL = 4'h0;
    localparam logic [3:0] CPWM_MODE_COMP = 4'hE;
    localparam int CPWM_LVL_P_BIT = 0;
    localparam int CPWM_LVL_N_BIT = 1;
    localparam logic [15:0] CPWM_RST_CNT = 16'h0000;
    localparam logic [15:0] CPWM_RST_CMP = 16'hFFFF;
    localparam logic [15:0] CPWM_RST_DT = 16'h0001;
    localparam logic [15:0] CPWM_ONE = 16'h0001;
    localparam logic CPWM_RST_DTEN = 1'b1;
    localparam logic [31:0] CPWM_ZERO32 = 32'h0000_0000;

    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
    } cpwm_pins_t;

    typedef enum logic [1:0] {
        CPWM_IDLE = 2'b00,
        CPWM_RUN = 2'b01
    } cpwm_state_t;

endpackage

// File: src/cpwm_phase.sv
`timescale 1ns/1ns
module cpwm_phase
    import cpwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic load,
    input wire logic up,
    input wire logic [CPWM_W-1:0] cnt3,
    input wire logic [CPWM_W-1:0] cnt4,
    input wire logic [CPWM_W-1:0] duty,
    input wire logic lvl_p,
    input wire logic lvl_n,
    input wire logic dt_en,
    output logic pos,
    output logic neg
);
    logic [CPWM_W-1:0] cmp_r;
    logic raw_p;
    logic raw_n;
    logic act_p;
    logic act_n;

    // Positive active while the lagging counter is under compare, negative
    // while the leading counter is above it: the offset forms the gap
    assign raw_p = run && (cnt3 < cmp_r);
    assign raw_n = run && (cnt4 > cmp_r);
    assign act_p = raw_p && !(dt_en && raw_n); // RULE12
    assign act_n = raw_n && !(dt_en && raw_p); // RULE12

    // Active level low when select is 0, inverted when 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_r <= CPWM_RST_CMP;
            pos <= 1'b1;
            neg <= 1'b1;
        end else begin
            if (load) begin
                cmp_r <= duty; // RULE9
            end
            pos <= act_p ? lvl_p : !lvl_p; // RULE1
            neg <= act_n ? lvl_n : !lvl_n; // RULE1
        end
    end
    wire unused_up = up;
endmodule

// File: tb/cpwm_properties.sv
`timescale 1ns/1ns
module cpwm_checker
    import cpwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire cpwm_pkg::cpwm_pins_t pwm_o
);
    logic [1:0] lvl_r;
    logic run_r;
    logic ran_r;
    logic dten_r;
    logic seen_r;
    wire logic wr = psel & penable & pready & pwrite & ~pslverr;
    wire logic rd_one = psel & penable & pready & ~pwrite & ~pslverr &
        (paddr == CPWM_ADDR_DTEN) & prdata[0];
    wire logic [2:0] ap = pwm_o.pos ^ {3{~lvl_r[0]}};
    wire logic [2:0] an = pwm_o.neg ^ {3{~lvl_r[1]}};
    wire logic [5:0] idle = {{3{~lvl_r[0]}}, {3{~lvl_r[1]}}};
    wire logic [2:0] both_on = ap & an;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= 2'h0;
            run_r <= 1'b0;
            ran_r <= 1'b0;
            dten_r <= 1'b1;
            seen_r <= 1'b0;
        end else begin
            if (rd_one) begin
                seen_r <= 1'b1;
            end
            if (wr) begin
                if (paddr == CPWM_ADDR_LEVEL && !run_r) begin
                    lvl_r <= pwdata[1:0];
                end
                if (paddr == CPWM_ADDR_MODE) begin
                    run_r <= pwdata[3:0] == CPWM_MODE_COMP;
                    ran_r <= ran_r | (pwdata[3:0] == CPWM_MODE_COMP);
                end
                // Enable clears only on a 0 write after a read saw 1
                if (paddr == CPWM_ADDR_DTEN) begin
                    if (!pwdata[0] && seen_r) begin
                        dten_r <= 1'b0;
                    end
                    seen_r <= 1'b0;
                end
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence quiet_s;
        !ran_r && !run_r && $stable(lvl_r);
    endsequence
    chk_ready_after: assert property (setup_s |=> pready)
        else $error("no answer after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 0)
        else $error("refused read not zero");
    chk_idle_quiet: assert property (!psel |-> !pready)
        else $error("answer without select");
    chk_reset_pins: assert property ($rose(presetn) |-> pwm_o == 6'h3F)
        else $error("pins not high after reset");
    chk_idle_level: assert property (quiet_s |-> pwm_o == idle)
        else $error("idle pins not inverse of level");
    chk_no_overlap: assert property (run_r && dten_r |-> !both_on)
        else $error("phases overlap");
endmodule
bind cpwm_top cpwm_checker cpwm_checker_i(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_o(pwm_o));

// File: tb/cpwm_gate_model.sv
`timescale 1ns/1ns
module cpwm_gate_model
    import cpwm_pkg::*;
(
    input wire logic pclk,
    input wire cpwm_pkg::cpwm_pins_t pins,
    input wire logic [1:0] act_lvl,
    input wire logic guard,
    output int shoots
);
    // Both switches of one leg on means shoot-through in the bridge
    wire logic [2:0] hi_on = pins.pos ~^ {3{act_lvl[0]}};
    wire logic [2:0] lo_on = pins.neg ~^ {3{act_lvl[1]}};
    initial begin
        shoots = 0;
        forever begin
            @(posedge pclk);
            if (guard && (hi_on & lo_on) != 3'h0) begin
                shoots <= shoots + 1;
            end
        end
    end
endmodule

// File: tb/cpwm_top_bench.sv
`timescale 1ns/1ns
module cpwm_top_bench;
    import cpwm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, guard = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] lvl = 2'h0;
    cpwm_pins_t pwm_o;
    int num_errors = 0, check_count = 0, shoots;
    cpwm_top cpwm_top_i(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_o(pwm_o));
    cpwm_gate_model cpwm_gate_model_i(.pclk(pclk), .pins(pwm_o),
        .act_lvl(lvl), .guard(guard), .shoots(shoots));
    initial forever #10 pclk = ~pclk;
    task automatic results;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input logic ee);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        check(rd, e, "read data");
        check({31'h0, er}, {31'h0, ee}, "slave error");
    endtask
    // Waits until every pin in the mask sits at the low active level
    task automatic wait_active(input logic [5:0] m, input string msg);
        int n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((pwm_o & m) != 6'h00 && n < 200);
        check(32'(n < 200), 32'h1, msg);
        if (n >= 200) begin
            results();
        end
    endtask
    task automatic t_reset;
        check({26'h0, pwm_o}, 32'h3F, "reset pins");
        rchk(CPWM_ADDR_DTEN, 32'h1, 1'b0);
        rchk(CPWM_ADDR_DTDATA, 32'h1, 1'b0);
        rchk(CPWM_ADDR_PERCMP, 32'hFFFF, 1'b0);
        rchk(CPWM_ADDR_CNT4, 32'h0, 1'b0);
        rchk(8'h38, 32'h0, 1'b1);
        rchk(8'h05, 32'h0, 1'b1);
    endtask
    task automatic t_levels;
        wr(CPWM_ADDR_LEVEL, 32'h3);
        repeat (2) @(posedge pclk);
        check({26'h0, pwm_o}, 32'h0, "inverted idle");
        wr(CPWM_ADDR_LEVEL, 32'h0);
        repeat (2) @(posedge pclk);
        check({26'h0, pwm_o}, 32'h3F, "normal idle");
    endtask
    task automatic t_entry;
        wr(CPWM_ADDR_DTDATA, 32'h4);
        wr(CPWM_ADDR_CYCBUF, 32'h32);
        wr(CPWM_ADDR_PERBUF, 32'h36);
        wr(CPWM_ADDR_DUTYU, 32'h14);
        wr(CPWM_ADDR_DUTYV, 32'h19);
        wr(CPWM_ADDR_DUTYW, 32'h1E);
        wr(CPWM_ADDR_CNT4, 32'h0);
        rchk(CPWM_ADDR_CYCDATA, 32'hFFFF, 1'b0);
        guard <= 1'b1;
        wr(CPWM_ADDR_MODE, {28'h0, CPWM_MODE_COMP});
        rchk(CPWM_ADDR_CYCDATA, 32'h32, 1'b0);
        rchk(CPWM_ADDR_PERCMP, 32'h36, 1'b0);
        wr(CPWM_ADDR_DTDATA, 32'h9);
        rchk(CPWM_ADDR_DTDATA, 32'h4, 1'b0);
        wait_active(6'h08, "U positive not active");
        wait_active(6'h01, "U negative not active");
        wait_active(6'h08, "U positive not active again");
        wait_active(6'h01, "U negative not active again");
        repeat (400) @(posedge pclk);
        check(32'(shoots), 32'h0, "shoot-through");
        guard <= 1'b0;
        wr(CPWM_ADDR_MODE, 32'h0);
    endtask
    task automatic t_no_dead;
        // Any enable write clears the read flag, so the next 0 write has no read before it
        wr(CPWM_ADDR_DTEN, 32'h1);
        wr(CPWM_ADDR_DTEN, 32'h0);
        rchk(CPWM_ADDR_DTEN, 32'h1, 1'b0);
        wr(CPWM_ADDR_DTEN, 32'h0);
        rchk(CPWM_ADDR_DTEN, 32'h0, 1'b0);
        wr(CPWM_ADDR_DTDATA, 32'h1);
        wr(CPWM_ADDR_PERBUF, 32'h33);
        wr(CPWM_ADDR_CNT4, 32'h0);
        wr(CPWM_ADDR_MODE, {28'h0, CPWM_MODE_COMP});
        rchk(CPWM_ADDR_PERCMP, 32'h33, 1'b0);
        wr(CPWM_ADDR_MODE, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_levels();
        t_entry();
        t_no_dead();
        results();
    end
endmodule
